// >>> bench/test_tmr_irq_stat.sv
// Self-checking bench of the timer interrupt enable and status block
`timescale 1ns/100ps
module test_tmr_irq_stat;
	import tmr_pkg::*;
	logic           core_clk        = 1'b0;
	logic           rst             = 1'b1;
	tmr_apb_req_s   req             = '0;
	tmr_apb_rsp_s   rsp;
	tmr_evt_s [2:0] evt;
	tmr_irq_s [2:0] irq;
	logic           cap;
	logic           pin_in;
	logic           pin_out;
	logic           pin_oe;
	logic [7:0]     r;
	logic           e;
	int             mismatches      = 0;
	int             samples_checked = 0;
	int             cap_cnt         = 0;
	int             gch[13]         = '{0, 0, 0, 0, 0, 1, 2, 2, 2, 1, 1, 1, 2};
	int             gb[13]          = '{4, 3, 2, 1, 0, 5, 5, 1, 0, 0, 1, 4, 4};

	tmr_irq_stat tmr_irq_stat_inst (.core_clk(core_clk), .rst(rst), .apb_req(req),
		.apb_rsp(rsp), .evt(evt), .ch2_general_reg_a_capture(cap),
		.ch2_a_capture_compare_pin_in(pin_in), .ch2_a_capture_compare_pin_out(pin_out),
		.ch2_a_capture_compare_pin_oe(pin_oe), .irq(irq));
	tmr_partner tmr_partner_inst (.core_clk(core_clk), .evt(evt), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_in(pin_in));

	initial begin
		forever #4 core_clk = ~core_clk;
	end

	// Counts capture strobes so every pulse is accounted for
	always @(posedge core_clk) begin
		if (cap === 1'b1) begin
			cap_cnt <= cap_cnt + 1;
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// No wait count is assumed; only the watchdog ends a stuck access
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= {24'h0, d};
		@(posedge core_clk);
		req.penable <= 1'b1;
		do @(posedge core_clk); while (rsp.pready !== 1'b1);
		r = rsp.prdata[7:0];
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge core_clk);
	endtask : xfer

	task automatic t_reset();
		for (int i = 0; i < 3; i++) begin
			xfer(0, OFF_IEN[i], 0);
			chk(r, 8'h40);
			xfer(0, OFF_STAT[i], 0);
			chk(r, 8'hC0);
		end
		xfer(0, OFF_FSEL, 0);
		chk(r, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic t_ien();
		for (int i = 0; i < 3; i++) begin
			xfer(1, OFF_IEN[i], 8'h7F);
			xfer(0, OFF_IEN[i], 0);
			chk(r, (i == 0) ? 8'h5F : 8'h73);
			xfer(1, OFF_IEN[i], 8'h40);
			xfer(0, OFF_IEN[i], 0);
			chk(r, 8'h40);
		end
		$display("test enable bits done");
	endtask : t_ien

	task automatic t_gate(input int ch, input int b);
		logic [7:0] m;
		m = 8'h01 << b;
		xfer(1, OFF_IEN[ch], 8'h40 | m);
		tmr_partner_inst.fire(ch, b);
		@(posedge core_clk);
		chk({2'b0, irq[ch]}, m);
		xfer(1, OFF_STAT[ch], 8'h00);
		chk({2'b0, irq[ch]}, m);
		xfer(0, OFF_STAT[ch], 0);
		chk(r, 8'hC0 | m);
		xfer(1, OFF_STAT[ch], m);
		chk({2'b0, irq[ch]}, m);
		xfer(1, OFF_STAT[ch], 8'h00);
		chk({2'b0, irq[ch]}, 8'h00);
		xfer(1, OFF_IEN[ch], 8'h40);
		tmr_partner_inst.fire(ch, b);
		@(posedge core_clk);
		chk({2'b0, irq[ch]}, 8'h00);
		xfer(0, OFF_STAT[ch], 0);
		xfer(1, OFF_STAT[ch], 8'h00);
		$display("test gate %0d %0d done", ch, b);
	endtask : t_gate

	task automatic t_dir();
		tmr_partner_inst.set_dir(2, 1'b0);
		tmr_partner_inst.set_dir(0, 1'b0);
		@(posedge core_clk);
		xfer(0, OFF_STAT[2], 0);
		chk(r, 8'h40);
		xfer(0, OFF_STAT[0], 0);
		chk(r, 8'hC0);
		tmr_partner_inst.set_dir(2, 1'b1);
		tmr_partner_inst.set_dir(0, 1'b1);
		$display("test direction done");
	endtask : t_dir

	task automatic t_cmp();
		logic [3:0] c;
		logic       x;
		for (int i = 0; i < 8; i++) begin
			c = i[3:0];
			xfer(1, OFF_FSEL, {4'h0, c});
			chk({7'h0, pin_oe}, {7'h0, c[1:0] != 2'b00});
			if (c[1:0] != 2'b00) begin
				chk({7'h0, pin_out}, {7'h0, c[2]});
				x = (c[1:0] == 2'b01) ? 1'b0 : (c[1:0] == 2'b10) ? 1'b1 : ~c[2];
				tmr_partner_inst.fire(2, 0);
				@(posedge core_clk);
				chk({7'h0, pin_out}, {7'h0, x});
				x = (c[1:0] == 2'b11) ? c[2] : x;
				tmr_partner_inst.fire(2, 0);
				@(posedge core_clk);
				chk({7'h0, pin_out}, {7'h0, x});
			end
			xfer(0, OFF_STAT[2], 0);
			xfer(1, OFF_STAT[2], 8'h00);
		end
		$display("test compare done");
	endtask : t_cmp

	task automatic t_cap();
		logic [3:0] c[4] = '{4'h8, 4'h9, 4'hA, 4'hE};
		for (int i = 0; i < 4; i++) begin
			xfer(1, OFF_FSEL, 8'h00);
			xfer(1, OFF_FSEL, {4'h0, c[i]});
			tmr_partner_inst.set_pin(1'b1);
			repeat (3) @(posedge core_clk);
			xfer(0, OFF_STAT[2], 0);
			chk(r, (c[i][1:0] == 2'b01) ? 8'hC0 : 8'hC1);
			xfer(1, OFF_STAT[2], 8'h00);
			tmr_partner_inst.set_pin(1'b0);
			repeat (3) @(posedge core_clk);
			xfer(0, OFF_STAT[2], 0);
			chk(r, (c[i][1:0] == 2'b00) ? 8'hC0 : 8'hC1);
			xfer(1, OFF_STAT[2], 8'h00);
		end
		chk(cap_cnt[7:0], 8'h06);
		xfer(0, 8'h1C, 0);
		chk({7'h0, e}, 8'h01);
		chk(r, 8'h00);
		$display("test capture done");
	endtask : t_cap

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_ien();
		for (int i = 0; i < 13; i++) begin
			t_gate(gch[i], gb[i]);
		end
		t_dir();
		t_cmp();
		t_cap();
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		end_of_test();
	end
endmodule : test_tmr_irq_stat

// >>> bench/tmr_partner.sv
// Counter datapath and pin driver model facing the timer status block
`timescale 1ns/100ps
module tmr_partner (
	// Clock
	input  wire logic               core_clk,
	// Block side
	output tmr_pkg::tmr_evt_s [2:0] evt,
	input  wire logic               pin_out,
	input  wire logic               pin_oe,
	output logic                    pin_in
);
	import tmr_pkg::*;
	tmr_evt_s [2:0] evt_q = {3{7'h40}};
	logic           drv_q = 1'b0;
	assign evt = evt_q;
	// Block wins the pin while it drives; otherwise the far end sets it
	assign pin_in = pin_oe ? pin_out : drv_q;
	// One-cycle pulse, as a counter wrap or match gives it
	task automatic fire(input int ch, input int b);
		@(posedge core_clk);
		evt_q[ch][b] <= 1'b1;
		@(posedge core_clk);
		evt_q[ch][b] <= 1'b0;
	endtask : fire
	task automatic set_dir(input int ch, input logic v);
		evt_q[ch].dir_up <= v;
	endtask : set_dir
	task automatic set_pin(input logic v);
		drv_q <= v;
	endtask : set_pin
endmodule : tmr_partner

// >>> design/tmr_irq_stat.sv
// Interrupt enable, status flags and channel 2 A function select of a three-channel timer
`timescale 1ns/100ps

module tmr_irq_stat (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	// APB slave
	input  wire tmr_pkg::tmr_apb_req_s  apb_req,
	output tmr_pkg::tmr_apb_rsp_s       apb_rsp,
	// Counter datapath events
	input  wire tmr_pkg::tmr_evt_s [2:0] evt,
	output logic                        ch2_general_reg_a_capture,
	// Channel 2 A pin
	input  wire logic                   ch2_a_capture_compare_pin_in,
	output logic                        ch2_a_capture_compare_pin_out,
	output logic                        ch2_a_capture_compare_pin_oe,
	// Interrupt requests
	output tmr_pkg::tmr_irq_s [2:0]     irq
);
	import tmr_pkg::*;

	tmr_state_s       q;
	tmr_state_s       d;
	logic [2:0][7:0]  rd_ien;
	logic [2:0][7:0]  rd_stat;
	logic [7:0]       rd_sel;
	logic             hit;
	logic             setup;
	logic             acc;
	logic             rise;
	logic             fall;
	logic             cap_hit;
	logic [2:0][7:0]  set_v;
	logic [2:0][7:0]  clr_v;

	// Read views and interrupt levels, one copy per channel
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ch
			assign rd_ien[g] = (q.ien[g] & CH_MASK[g]) | IEN_FIXED;
			if (g == 0) begin : g_c0
				assign rd_stat[g] = {1'b1, STAT_FIXED[6:0] | (q.flag[g][6:0] & CH_MASK[g][6:0])};
			end else begin : g_c12
				assign rd_stat[g] = {q.dir_up[g], STAT_FIXED[6:0] | (q.flag[g][6:0] & CH_MASK[g][6:0])};
			end
			assign irq[g].underflow_irq = q.flag[g][BIT_UDF] & q.ien[g][BIT_UDF] & CH_MASK[g][BIT_UDF];
			assign irq[g].overflow_irq  = q.flag[g][BIT_OVF] & q.ien[g][BIT_OVF];
			assign irq[g].cc_d_irq      = q.flag[g][BIT_CC_D] & q.ien[g][BIT_CC_D] & CH_MASK[g][BIT_CC_D];
			assign irq[g].cc_c_irq      = q.flag[g][BIT_CC_C] & q.ien[g][BIT_CC_C] & CH_MASK[g][BIT_CC_C];
			assign irq[g].cc_b_irq      = q.flag[g][BIT_CC_B] & q.ien[g][BIT_CC_B];
			assign irq[g].cc_a_irq      = q.flag[g][BIT_CC_A] & q.ien[g][BIT_CC_A];
		end
	endgenerate

	// Zero-wait slave: read data is latched in setup, so the access phase answers at once
	assign setup           = apb_req.psel & ~apb_req.penable;
	assign acc             = apb_req.psel & apb_req.penable;
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = acc & ~hit;
	assign apb_rsp.prdata  = q.prdata;

	assign ch2_general_reg_a_capture     = q.cap_stb;
	assign ch2_a_capture_compare_pin_out = q.pin;
	assign ch2_a_capture_compare_pin_oe  = ~q.fsel[FS_CAPT] & (q.fsel[1:0] != 2'b00);

	// Inputs are synchronous, so one stored sample is enough for edge detection
	assign rise = ch2_a_capture_compare_pin_in & ~q.pin_prev;
	assign fall = ~ch2_a_capture_compare_pin_in & q.pin_prev;
	assign cap_hit = q.fsel[FS_CAPT] & (q.fsel[1] ? (rise | fall) : (q.fsel[0] ? fall : rise));

	always_comb begin
		d      = q;
		hit    = 1'b0;
		rd_sel = 8'h00;
		set_v  = '0;
		clr_v  = '0;
		if (apb_req.paddr == OFF_FSEL) begin
			hit    = 1'b1;
			rd_sel = {4'h0, q.fsel};
		end
		for (int i = 0; i < 3; i++) begin
			if (apb_req.paddr == OFF_IEN[i]) begin
				hit    = 1'b1;
				rd_sel = rd_ien[i];
			end
			if (apb_req.paddr == OFF_STAT[i]) begin
				hit    = 1'b1;
				rd_sel = rd_stat[i];
			end
		end
		if (setup) begin
			d.prdata = {24'h00_0000, rd_sel};
		end
		d.pin_prev = ch2_a_capture_compare_pin_in;
		d.cap_stb  = cap_hit;
		for (int i = 0; i < 3; i++) begin
			set_v[i][BIT_UDF]  = evt[i].udf;
			set_v[i][BIT_OVF]  = evt[i].ovf;
			set_v[i][BIT_CC_D] = evt[i].cc_d;
			set_v[i][BIT_CC_C] = evt[i].cc_c;
			set_v[i][BIT_CC_B] = evt[i].cc_b;
			set_v[i][BIT_CC_A] = evt[i].cc_a;
			if (i == 2) begin
				set_v[i][BIT_CC_A] = q.fsel[FS_CAPT] ? cap_hit : evt[i].cc_a;
			end
			set_v[i] = set_v[i] & CH_MASK[i];
			if (i != 0) begin
				d.dir_up[i] = evt[i].dir_up;
			end
			if (acc && apb_req.pwrite && apb_req.paddr == OFF_IEN[i]) begin
				d.ien[i] = (q.ien[i] & ~CH_MASK[i]) | (apb_req.pwdata[7:0] & CH_MASK[i]);
			end
			// Only bits seen as one by an earlier read may be cleared by a zero
			if (acc && apb_req.pwrite && apb_req.paddr == OFF_STAT[i]) begin
				clr_v[i] = ~apb_req.pwdata[7:0] & q.armed[i] & CH_MASK[i];
			end
			if (acc && !apb_req.pwrite && apb_req.paddr == OFF_STAT[i]) begin
				d.armed[i] = q.armed[i] | (q.prdata[7:0] & CH_MASK[i]);
			end else begin
				d.armed[i] = q.armed[i] & ~clr_v[i];
			end
			// A new event in the clearing cycle wins, so it is not lost
			d.flag[i] = (q.flag[i] & ~clr_v[i]) | set_v[i];
		end
		if (!q.fsel[FS_CAPT] && evt[2].cc_a) begin
			case (q.fsel[1:0])
				2'b01:   d.pin = 1'b0;
				2'b10:   d.pin = 1'b1;
				2'b11:   d.pin = ~q.pin;
				default: d.pin = q.pin;
			endcase
		end
		// A new output mode loads its initial level, overriding a same-cycle match
		if (acc && apb_req.pwrite && apb_req.paddr == OFF_FSEL) begin
			d.fsel = apb_req.pwdata[3:0];
			if (!apb_req.pwdata[FS_CAPT]) begin
				d.pin = apb_req.pwdata[FS_INIT];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			q <= STATE_RST;
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// Reset is a disable condition, so look at the first cycle after it falls
	ien_reset_a: assert property ($fell(rst) |-> (rd_ien == {3{IEN_RST}}))
		else $error("enable registers not 40 hex after reset");
	stat_reset_a: assert property ($fell(rst) |-> (rd_stat == {3{STAT_RST}}))
		else $error("status registers not C0 hex after reset");
	ien_fixed_a: assert property (rd_ien[1][7:6] == 2'b01 && rd_ien[0][7:5] == 3'b010)
		else $error("enable fixed bits read wrong");
	ien_resv_a: assert property (rd_ien[2][3:2] == 2'b00 && rd_ien[1][3:2] == 2'b00)
		else $error("reserved enable bits not zero");
	stat_dir_a: assert property (rd_stat[2][7] == $past(evt[2].dir_up))
		else $error("direction bit wrong");
	stat0_dir_a: assert property (rd_stat[0][7])
		else $error("channel 0 direction bit not one");
	udf_set_a: assert property (evt[1].udf |=> q.flag[1][BIT_UDF])
		else $error("underflow flag not set");
	set_wins_a: assert property ((evt[2].ovf && acc && apb_req.pwrite
		&& apb_req.paddr == OFF_STAT[2]) |=> q.flag[2][BIT_OVF])
		else $error("event lost during clear");
	clr_needs_read_a: assert property ((q.flag[1][BIT_CC_B] && !q.armed[1][BIT_CC_B])
		|=> q.flag[1][BIT_CC_B])
		else $error("flag cleared without prior read");
	ovf_irq_a: assert property ((evt[0].ovf && q.ien[0][BIT_OVF]
		&& !(acc && apb_req.pwrite)) |=> irq[0].overflow_irq)
		else $error("overflow request not raised");
	cmp_level_a: assert property ((!q.fsel[FS_CAPT] && q.fsel[1:0] == 2'b10 && evt[2].cc_a
		&& !(acc && apb_req.pwrite)) |=> ch2_a_capture_compare_pin_out)
		else $error("compare did not drive pin high");
	cmp_toggle_a: assert property ((!q.fsel[FS_CAPT] && q.fsel[1:0] == 2'b11 && evt[2].cc_a
		&& !(acc && apb_req.pwrite)) |=> (q.pin != $past(q.pin)))
		else $error("compare did not toggle pin");
	cap_rise_a: assert property ((q.fsel[FS_CAPT] && q.fsel[1:0] == 2'b00 && rise)
		|=> (ch2_general_reg_a_capture && q.flag[2][BIT_CC_A]))
		else $error("rising capture missed");

	// Fixed and reserved read bits, ready and error response
	ien0_b5_a: assert property (rd_ien[0][5] == 1'b0)
		else $error("channel 0 enable bit 5 not zero");

	ien2_fixed_a: assert property (rd_ien[2][7:6] == 2'b01)
		else $error("channel 2 enable fixed bits wrong");

	ien0_b6_a: assert property (rd_ien[0][6])
		else $error("channel 0 enable bit 6 not one");

	stat0_fixed_a: assert property (rd_stat[0][7:5] == 3'b110)
		else $error("channel 0 status fixed bits wrong");

	stat_resv_a: assert property (rd_stat[1][3:2] == 2'b00
		&& rd_stat[2][3:2] == 2'b00)
		else $error("reserved status bits not zero");

	prdata_hi_a: assert property (apb_rsp.prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");

	pready_on_a: assert property (apb_rsp.pready)
		else $error("ready not high");

	slverr_unmap_a: assert property ((acc && !hit) |-> apb_rsp.pslverr)
		else $error("unmapped access without error");

	// Request levels follow flag and enable
	udf1_irq_a: assert property (irq[1].underflow_irq
		== (q.flag[1][BIT_UDF] & q.ien[1][BIT_UDF]))
		else $error("channel 1 underflow request wrong");

	udf2_irq_a: assert property (irq[2].underflow_irq
		== (q.flag[2][BIT_UDF] & q.ien[2][BIT_UDF]))
		else $error("channel 2 underflow request wrong");

	udf0_irq_a: assert property (!irq[0].underflow_irq)
		else $error("channel 0 underflow request raised");

	ovf1_irq_a: assert property (irq[1].overflow_irq
		== (q.flag[1][BIT_OVF] & q.ien[1][BIT_OVF]))
		else $error("channel 1 overflow request wrong");

	ovf2_irq_a: assert property (irq[2].overflow_irq
		== (q.flag[2][BIT_OVF] & q.ien[2][BIT_OVF]))
		else $error("channel 2 overflow request wrong");

	ccd0_irq_a: assert property (irq[0].cc_d_irq
		== (q.flag[0][BIT_CC_D] & q.ien[0][BIT_CC_D]))
		else $error("channel 0 D request wrong");

	ccc0_irq_a: assert property (irq[0].cc_c_irq
		== (q.flag[0][BIT_CC_C] & q.ien[0][BIT_CC_C]))
		else $error("channel 0 C request wrong");

	ccdc_resv_a: assert property (!irq[1].cc_d_irq && !irq[1].cc_c_irq
		&& !irq[2].cc_d_irq && !irq[2].cc_c_irq)
		else $error("reserved request raised");

	ccb0_irq_a: assert property (irq[0].cc_b_irq
		== (q.flag[0][BIT_CC_B] & q.ien[0][BIT_CC_B]))
		else $error("channel 0 B request wrong");

	cca2_irq_a: assert property (irq[2].cc_a_irq
		== (q.flag[2][BIT_CC_A] & q.ien[2][BIT_CC_A]))
		else $error("channel 2 A request wrong");

	// Enable register writes
	ien1_write_a: assert property ((acc && apb_req.pwrite && apb_req.paddr == OFF_IEN[1])
		|=> (rd_ien[1] == (($past(apb_req.pwdata[7:0]) & CH_MASK[1]) | IEN_FIXED)))
		else $error("channel 1 enable write wrong");

	ien0_write_a: assert property ((acc && apb_req.pwrite && apb_req.paddr == OFF_IEN[0])
		|=> (rd_ien[0] == (($past(apb_req.pwdata[7:0]) & CH_MASK[0]) | IEN_FIXED)))
		else $error("channel 0 enable write wrong");

	ien_hold_a: assert property (!(acc && apb_req.pwrite) |=> $stable(q.ien))
		else $error("enable changed without write");

	// Flag set and clear
	cca0_noset_a: assert property ((!q.flag[0][BIT_CC_A] && !evt[0].cc_a)
		|=> !q.flag[0][BIT_CC_A])
		else $error("channel 0 A flag set without event");

	ovf1_noset_a: assert property ((!q.flag[1][BIT_OVF] && !evt[1].ovf)
		|=> !q.flag[1][BIT_OVF])
		else $error("channel 1 overflow flag set without event");

	ovf0_hold_a: assert property ((q.flag[0][BIT_OVF]
		&& !(acc && apb_req.pwrite && apb_req.paddr == OFF_STAT[0])) |=> q.flag[0][BIT_OVF])
		else $error("channel 0 overflow flag lost");

	cca0_clr_a: assert property ((acc && apb_req.pwrite && apb_req.paddr == OFF_STAT[0]
		&& !apb_req.pwdata[BIT_CC_A] && q.armed[0][BIT_CC_A] && !evt[0].cc_a)
		|=> !q.flag[0][BIT_CC_A])
		else $error("channel 0 A flag not cleared");

	udf2_clr_a: assert property ((acc && apb_req.pwrite && apb_req.paddr == OFF_STAT[2]
		&& !apb_req.pwdata[BIT_UDF] && q.armed[2][BIT_UDF] && !evt[2].udf)
		|=> !q.flag[2][BIT_UDF])
		else $error("channel 2 underflow flag not cleared");

	ovf2_set_a: assert property (evt[2].ovf |=> q.flag[2][BIT_OVF])
		else $error("channel 2 overflow flag not set");

	udf2_set_a: assert property (evt[2].udf |=> q.flag[2][BIT_UDF])
		else $error("channel 2 underflow flag not set");

	udf0_never_a: assert property (!q.flag[0][BIT_UDF])
		else $error("channel 0 underflow flag set");

	cca2_cmp_a: assert property ((!q.fsel[FS_CAPT] && evt[2].cc_a)
		|=> q.flag[2][BIT_CC_A])
		else $error("compare did not set flag A");

	// Capture edges
	cap_fall_a: assert property ((q.fsel[FS_CAPT] && q.fsel[1:0] == 2'b01 && fall)
		|=> (ch2_general_reg_a_capture && q.flag[2][BIT_CC_A]))
		else $error("falling capture missed");

	cap_both_a: assert property ((q.fsel[FS_CAPT] && q.fsel[1] && (rise || fall))
		|=> ch2_general_reg_a_capture)
		else $error("both-edge capture missed");

	cap_none_a: assert property ((q.fsel[FS_CAPT] && q.fsel[1:0] == 2'b00 && !rise)
		|=> !ch2_general_reg_a_capture)
		else $error("capture without rising edge");

	cap_off_a: assert property (!q.fsel[FS_CAPT] |=> !ch2_general_reg_a_capture)
		else $error("capture in output mode");

	// Pin drive
	oe_capt_a: assert property (q.fsel[FS_CAPT] |-> !ch2_a_capture_compare_pin_oe)
		else $error("pin driven in capture mode");

	oe_off_a: assert property ((q.fsel[1:0] == 2'b00) |-> !ch2_a_capture_compare_pin_oe)
		else $error("pin driven while disabled");

	oe_on_a: assert property ((!q.fsel[FS_CAPT] && q.fsel[1:0] != 2'b00)
		|-> ch2_a_capture_compare_pin_oe)
		else $error("pin not driven in output mode");

	cmp_low_a: assert property ((!q.fsel[FS_CAPT] && q.fsel[1:0] == 2'b01 && evt[2].cc_a
		&& !(acc && apb_req.pwrite)) |=> !ch2_a_capture_compare_pin_out)
		else $error("compare did not drive pin low");

	init_lvl_a: assert property ((acc && apb_req.pwrite && apb_req.paddr == OFF_FSEL
		&& !apb_req.pwdata[FS_CAPT])
		|=> (ch2_a_capture_compare_pin_out == $past(apb_req.pwdata[FS_INIT])))
		else $error("initial pin level wrong");

	fsel_write_a: assert property ((acc && apb_req.pwrite && apb_req.paddr == OFF_FSEL)
		|=> (q.fsel == $past(apb_req.pwdata[3:0])))
		else $error("function select write wrong");

	pin_hold_a: assert property ((!evt[2].cc_a && !(acc && apb_req.pwrite))
		|=> $stable(ch2_a_capture_compare_pin_out))
		else $error("pin changed without cause");

endmodule : tmr_irq_stat

// >>> design/tmr_pkg.sv
// Shared constants, register map and carrier types of the timer interrupt/status block
package tmr_pkg;

	// Register byte offsets on the APB slave
	localparam logic [7:0]       OFF_FSEL = 8'h00;
	localparam logic [2:0][7:0]  OFF_IEN  = {8'h0C, 8'h08, 8'h04};
	localparam logic [2:0][7:0]  OFF_STAT = {8'h18, 8'h14, 8'h10};

	// Reset values
	localparam logic [3:0]       FSEL_RST = 4'h0;
	localparam logic [7:0]       IEN_RST  = 8'h40;
	localparam logic [7:0]       STAT_RST = 8'hC0;

	// Fixed read bits: enable bit 6 reads one, bit 7 zero; status bit 6 reads one
	localparam logic [7:0]       IEN_FIXED  = 8'h40;
	localparam logic [7:0]       STAT_FIXED = 8'h40;

	// Implemented enable / flag bits per channel (index 0 is channel 0)
	localparam logic [2:0][7:0]  CH_MASK = {8'h33, 8'h33, 8'h1F};

	// Bit positions shared by enable and status registers; BIT_DIR is status only
	localparam int BIT_CC_A  = 0;
	localparam int BIT_CC_B  = 1;
	localparam int BIT_CC_C  = 2;
	localparam int BIT_CC_D  = 3;
	localparam int BIT_OVF   = 4;
	localparam int BIT_UDF   = 5;
	localparam int BIT_DIR   = 7;

	// Function select field positions
	localparam int FS_CAPT   = 3;
	localparam int FS_INIT   = 2;

	// Events from the counter datapath, one set per channel
	typedef struct packed {
		logic dir_up;
		logic udf;
		logic ovf;
		logic cc_d;
		logic cc_c;
		logic cc_b;
		logic cc_a;
	} tmr_evt_s;

	// Interrupt request levels, one set per channel
	typedef struct packed {
		logic underflow_irq;
		logic overflow_irq;
		logic cc_d_irq;
		logic cc_c_irq;
		logic cc_b_irq;
		logic cc_a_irq;
	} tmr_irq_s;

	// APB request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} tmr_apb_req_s;

	// APB answer to the master
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} tmr_apb_rsp_s;

	// Complete state of the block
	typedef struct packed {
		logic [3:0]      fsel;
		logic [2:0][7:0] ien;
		logic [2:0][7:0] flag;
		logic [2:0][7:0] armed;
		logic [2:0]      dir_up;
		logic            pin;
		logic            pin_prev;
		logic            cap_stb;
		logic [31:0]     prdata;
	} tmr_state_s;

	localparam tmr_state_s STATE_RST = '{
		fsel:     FSEL_RST,
		ien:      {IEN_RST, IEN_RST, IEN_RST},
		flag:     {3{8'h00}},
		armed:    {3{8'h00}},
		dir_up:   3'h7,
		pin:      1'b0,
		pin_prev: 1'b0,
		cap_stb:  1'b0,
		prdata:   32'h0000_0000
	};

endpackage : tmr_pkg
